/* File: common/sca_defines.vh */
// register indices, field positions, reset values and timing for the sc type a control block
// assumes the includer maps byte address = 4 * index, bank bit above the 8-bit index
`ifndef SCA_DEFINES_VH
`define SCA_DEFINES_VH
`define SCA_IDX_B10_CR0  8'h80
`define SCA_IDX_B10_CR1  8'h81
`define SCA_IDX_B12_CR0  8'h88
`define SCA_IDX_B12_CR1  8'h89
`define SCA_IDX_B21_CR0  8'h94
`define SCA_IDX_B21_CR1  8'h95
`define SCA_IDX_B23_CR0  8'h9C
`define SCA_IDX_B23_CR1  8'h9D
`define SCA_IDX_MISC     8'hA0
`define SCA_IDX_STATUS   8'hA1
`define SCA_BANK_BIT     8
`define SCA_CR0_FEEDBACK_CAP_SELECT     7
`define SCA_CR0_INV      6
`define SCA_CR0_SIGN     5
`define SCA_CAP_MSB      4
`define SCA_CR1_MUX_MSB  7
`define SCA_CR1_MUX_LSB  5
`define SCA_MISC_HOLDDIS 6
`define SCA_RST_CTRL     8'h00
`define SCA_RST_MISC     8'h00
`define SCA_RESP_OKAY    2'b00
`define SCA_RESP_SLVERR  2'b10
`define SCA_CNT_W        12
`define SCA_MUX_NEIGHBOR 3'h4
`define SCA_MUX_RESERVED 3'h7
`define SCA_CSRC_FIXED   2'h0
`define SCA_CSRC_SAME_A  2'h1
`define SCA_CSRC_NONE    2'h3
`endif

/* File: hw/sca_sync.v */
// three-stage synchroniser for phase inputs arriving from the analog clock domain
// assumes inputs are asynchronous; output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sca_sync #(
  parameter W = 2
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer i;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      dout <= {W{1'b0}};
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (i = 0; i < W; i = i + 1)
        if (s2_r[i] == s3_r[i])
          dout[i] <= s3_r[i];
    end
  end
endmodule
`default_nettype wire

/* File: hw/sca_switch.v */
// per-block switch phasing: internal phases, bottom-plate sampling, column bus gating
// assumes synchronised external phases; half of phase two is learned from the previous one
`timescale 1ns/1ps
`default_nettype none
`include "sca_defines.vh"
module sca_switch #(
  parameter CNT_W = `SCA_CNT_W
) (
  input  wire clk,
  input  wire rst_n,
  input  wire ext_ph1,
  input  wire ext_ph2,
  input  wire invert,
  input  wire sign,
  input  wire hold_dis,
  input  wire bus_en,
  output reg  int_ph1,
  output reg  int_ph2,
  output reg  samp_in,
  output reg  samp_ref,
  output reg  bus_conn
);
  reg  [CNT_W-1:0] cnt_r;
  reg  [CNT_W-1:0] len_r;
  wire             p1 = invert ? ext_ph2 : ext_ph1;
  wire             p2 = invert ? ext_ph1 : ext_ph2;
  // first phase two after reset reaches its half only after 2047 cycles: len_r starts saturated
  wire             late = (cnt_r >= {1'b0, len_r[CNT_W-1:1]});
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r    <= {CNT_W{1'b0}};
      len_r    <= {CNT_W{1'b1}};
      int_ph1  <= 1'b0;
      int_ph2  <= 1'b0;
      samp_in  <= 1'b0;
      samp_ref <= 1'b0;
      bus_conn <= 1'b0;
    end
    else
    begin
      int_ph1  <= p1; // RULE_02
      int_ph2  <= p2; // RULE_02
      samp_in  <= sign ? p2 : p1; // RULE_06
      samp_ref <= sign ? p1 : p2; // RULE_06
      if (p2)
      begin
        if (cnt_r != {CNT_W{1'b1}})
          cnt_r <= cnt_r + 1'b1;
      end
      else if (cnt_r != {CNT_W{1'b0}})
      begin
        len_r <= cnt_r;
        cnt_r <= {CNT_W{1'b0}};
      end
      // bus floats in phase one and, with invert and hold_dis clear, early phase two: sample and hold on the bus capacitance
      bus_conn <= bus_en & p2 & (late | invert | hold_dis); // RULE_03 RULE_04 RULE_05 RULE_14
    end
  end
endmodule
`default_nettype wire

/* File: hw/sca_ctrl.v */
// control registers and switch phasing for four sc type a blocks, axi4-lite slave
// assumes phase pins from the analog clock generator, non-overlapping, slow against CLOCK
`timescale 1ns/1ps
`default_nettype none
`include "sca_defines.vh"
// Overview of operation
// (RULE_01) control zero bit 7 picks feedback cap: clear 16 units, set 32 units
// (RULE_02) phase invert bit swaps internal phase one between external phase one and two
// (RULE_03) enabled output drives the bus only in the last half of phase two
// (RULE_04) phase invert set: enabled output drives the bus for all of phase two
// (RULE_05) global hold disable: all enabled outputs drive for their whole phase two
// (RULE_06) sampling order bit chooses whether input or reference is taken on phase one
// (RULE_07) control zero bits 4..0 give the a-path cap size, 0 to 31 units
// (RULE_08) control one bits 4..0 give the b-path cap size, 0 to 31 units
// (RULE_09) top mux bit picks the c source and forces a and c together
// (RULE_10) mux codes decode per instance; 000-011 vary a, 100 selects neighbour
// (RULE_11) software must not program mux codes 101, 110 or 111
// (RULE_12) control zero instances sit at 80h, 88h, 94h, 9Ch in either bank
// (RULE_13) control one instances sit at 81h, 89h, 95h, 9Dh in either bank
// (RULE_14) column bus enable clear keeps the block off the bus regardless of phasing
// (RULE_15) all control bits clear at reset and read back what was written
module sca_ctrl #(
  parameter CNT_W = `SCA_CNT_W
) (
  input  wire        CLOCK,
  input  wire        RESETN,
  input  wire [11:0] S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [11:0] S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  input  wire        PHASE_ONE,
  input  wire        PHASE_TWO,
  output reg  [3:0]  FEEDBACK_CAP_32,
  output reg  [19:0] A_PATH_CAP_SIZE,
  output reg  [19:0] B_PATH_CAP_SIZE,
  output reg  [11:0] A_INPUT_INDEX,
  output reg  [7:0]  C_INPUT_INDEX,
  output wire [3:0]  INT_PHASE_ONE,
  output wire [3:0]  INT_PHASE_TWO,
  output wire [3:0]  SAMPLE_INPUT,
  output wire [3:0]  SAMPLE_REF,
  output wire [3:0]  BUS_CONNECT
);
  // slot 0..3 control zero, 4..7 control one, 8 misc, 9 status, 15 unmapped
  // index bit 8 is the bank bit and is not decoded, so both banks reach one register
  function [3:0] slot;
    input [9:0] idx;
    begin
      slot = 4'hF;
      if (idx[9] == 1'b0) // RULE_12 RULE_13
      begin
        case (idx[7:0])
          `SCA_IDX_B10_CR0: slot = 4'h0;
          `SCA_IDX_B12_CR0: slot = 4'h1;
          `SCA_IDX_B21_CR0: slot = 4'h2;
          `SCA_IDX_B23_CR0: slot = 4'h3;
          `SCA_IDX_B10_CR1: slot = 4'h4;
          `SCA_IDX_B12_CR1: slot = 4'h5;
          `SCA_IDX_B21_CR1: slot = 4'h6;
          `SCA_IDX_B23_CR1: slot = 4'h7;
          `SCA_IDX_MISC:    slot = 4'h8;
          `SCA_IDX_STATUS:  slot = 4'h9;
          default:          slot = 4'hF;
        endcase
      end
    end
  endfunction

  // reserved codes give a recognisable index rather than guessing a source
  // top bit selects the neighbour only with low bits 00; codes 101 to 111 give the reserved index
  function [2:0] a_index;
    input [2:0] code;
    begin
      if (code[2] && code[1:0] != 2'b00)
        a_index = `SCA_MUX_RESERVED; // RULE_11
      else if (code[2])
        a_index = `SCA_MUX_NEIGHBOR; // RULE_09 RULE_10
      else
        a_index = code; // RULE_10
    end
  endfunction

  function [1:0] c_index;
    input [2:0] code;
    begin
      if (code[2] && code[1:0] != 2'b00)
        c_index = `SCA_CSRC_NONE; // RULE_11
      else if (code[2])
        c_index = `SCA_CSRC_SAME_A; // RULE_09
      else
        c_index = `SCA_CSRC_FIXED; // RULE_10
    end
  endfunction

  reg  [7:0]  cr0_r [0:3];
  reg  [7:0]  cr1_r [0:3];
  reg  [7:0]  misc_r;
  reg         aw_hold_r;
  reg  [9:0]  aw_idx_r;
  reg         w_hold_r;
  reg  [7:0]  w_data_r;
  reg         w_lane_r;

  wire        aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
  wire        w_take  = S_AXI_WVALID & S_AXI_WREADY;
  wire        ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
  wire        do_wr   = aw_hold_r & w_hold_r & ~S_AXI_BVALID;
  wire        aw_hold_nxt = (aw_hold_r | aw_take) & ~do_wr;
  wire        w_hold_nxt  = (w_hold_r | w_take) & ~do_wr;
  wire        rvalid_nxt  = (S_AXI_RVALID & ~S_AXI_RREADY) | ar_take;
  wire [3:0]  wr_slot = slot(aw_idx_r);
  wire [3:0]  rd_slot = slot(S_AXI_ARADDR[11:2]);
  wire [1:0]  ph_sync;
  wire [3:0]  bus_en  = misc_r[3:0];
  wire        hold_dis = misc_r[`SCA_MISC_HOLDDIS];
  reg  [7:0]  rd_byte;
  integer     k;
  integer     j;
  integer     n;

  // both phase pins share one synchroniser so their relative skew stays within a clock
  sca_sync #(
    .W (2)
  ) u_sync (
    .clk   (CLOCK),
    .rst_n (RESETN),
    .din   ({PHASE_TWO, PHASE_ONE}),
    .dout  (ph_sync)
  );

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : blk
      sca_switch #(
        .CNT_W (CNT_W)
      ) u_sw (
        .clk      (CLOCK),
        .rst_n    (RESETN),
        .ext_ph1  (ph_sync[0]),
        .ext_ph2  (ph_sync[1]),
        .invert   (cr0_r[g][`SCA_CR0_INV]),
        .sign     (cr0_r[g][`SCA_CR0_SIGN]),
        .hold_dis (hold_dis),
        .bus_en   (bus_en[g]),
        .int_ph1  (INT_PHASE_ONE[g]),
        .int_ph2  (INT_PHASE_TWO[g]),
        .samp_in  (SAMPLE_INPUT[g]),
        .samp_ref (SAMPLE_REF[g]),
        .bus_conn (BUS_CONNECT[g])
      );
    end
  endgenerate

  // status is read live: it shows the switch outputs of this very cycle
  always @*
  begin
    rd_byte = 8'h00;
    case (rd_slot)
      4'h0: rd_byte = cr0_r[0]; // RULE_15
      4'h1: rd_byte = cr0_r[1]; // RULE_15
      4'h2: rd_byte = cr0_r[2]; // RULE_15
      4'h3: rd_byte = cr0_r[3]; // RULE_15
      4'h4: rd_byte = cr1_r[0]; // RULE_15
      4'h5: rd_byte = cr1_r[1]; // RULE_15
      4'h6: rd_byte = cr1_r[2]; // RULE_15
      4'h7: rd_byte = cr1_r[3]; // RULE_15
      4'h8: rd_byte = misc_r;
      4'h9: rd_byte = {INT_PHASE_TWO, BUS_CONNECT};
      default: rd_byte = 8'h00;
    endcase
  end

  // write channel: address and data taken in either order, answer after both
  // readies are registered, so no path runs from a valid to a ready
  always @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `SCA_RESP_OKAY;
      aw_hold_r     <= 1'b0;
      aw_idx_r      <= 10'h000;
      w_hold_r      <= 1'b0;
      w_data_r      <= 8'h00;
      w_lane_r      <= 1'b0;
      misc_r        <= `SCA_RST_MISC;
      for (k = 0; k < 4; k = k + 1)
      begin
        cr0_r[k] <= `SCA_RST_CTRL; // RULE_15
        cr1_r[k] <= `SCA_RST_CTRL; // RULE_15
      end
    end
    else
    begin
      aw_hold_r     <= aw_hold_nxt;
      w_hold_r      <= w_hold_nxt;
      S_AXI_AWREADY <= ~aw_hold_nxt;
      S_AXI_WREADY  <= ~w_hold_nxt;
      if (aw_take)
        aw_idx_r <= S_AXI_AWADDR[11:2];
      if (w_take)
      begin
        w_data_r <= S_AXI_WDATA[7:0];
        w_lane_r <= S_AXI_WSTRB[0];
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
      if (do_wr)
      begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (wr_slot == 4'hF) ? `SCA_RESP_SLVERR : `SCA_RESP_OKAY;
        // only byte lane 0 carries data; a write without it changes nothing
        if (w_lane_r)
        begin
          case (wr_slot)
            4'h0: cr0_r[0] <= w_data_r; // RULE_12
            4'h1: cr0_r[1] <= w_data_r; // RULE_12
            4'h2: cr0_r[2] <= w_data_r; // RULE_12
            4'h3: cr0_r[3] <= w_data_r; // RULE_12
            4'h4: cr1_r[0] <= w_data_r; // RULE_13
            4'h5: cr1_r[1] <= w_data_r; // RULE_13
            4'h6: cr1_r[2] <= w_data_r; // RULE_13
            4'h7: cr1_r[3] <= w_data_r; // RULE_13
            4'h8: misc_r <= w_data_r;
            default: misc_r <= misc_r;
          endcase
        end
      end
    end
  end

  // read channel: one cycle from address taken to data valid
  always @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `SCA_RESP_OKAY;
    end
    else
    begin
      S_AXI_RVALID  <= rvalid_nxt;
      S_AXI_ARREADY <= ~rvalid_nxt;
      if (ar_take)
      begin
        S_AXI_RDATA <= {24'h000000, rd_byte};
        S_AXI_RRESP <= (rd_slot == 4'hF) ? `SCA_RESP_SLVERR : `SCA_RESP_OKAY;
      end
    end
  end

  // static decode of fields to the analog switch controls
  always @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      FEEDBACK_CAP_32 <= 4'h0;
      A_PATH_CAP_SIZE <= 20'h00000;
      B_PATH_CAP_SIZE <= 20'h00000;
    end
    else
    begin
      for (j = 0; j < 4; j = j + 1)
      begin
        FEEDBACK_CAP_32[j] <= cr0_r[j][`SCA_CR0_FEEDBACK_CAP_SELECT]; // RULE_01
        A_PATH_CAP_SIZE[j*5 +: 5] <= cr0_r[j][`SCA_CAP_MSB:0]; // RULE_07
        B_PATH_CAP_SIZE[j*5 +: 5] <= cr1_r[j][`SCA_CAP_MSB:0]; // RULE_08
      end
    end
  end

  // mux decode is registered too, so a code change never glitches the source switches
  always @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      A_INPUT_INDEX <= 12'h000;
      C_INPUT_INDEX <= 8'h00;
    end
    else
    begin
      for (n = 0; n < 4; n = n + 1)
      begin
        A_INPUT_INDEX[n*3 +: 3] <= a_index(cr1_r[n][`SCA_CR1_MUX_MSB:`SCA_CR1_MUX_LSB]); // RULE_10
        C_INPUT_INDEX[n*2 +: 2] <= c_index(cr1_r[n][`SCA_CR1_MUX_MSB:`SCA_CR1_MUX_LSB]); // RULE_09
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/sca_ctrl_properties.sv */
// port-level checks for sca_ctrl: mux decode, phasing, axi handshakes
// assumes one CLOCK domain, RESETN async active low
`timescale 1ns/1ps
`default_nettype none
module sca_ctrl_properties (
  input wire logic        CLOCK,
  input wire logic        RESETN,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [11:0] A_INPUT_INDEX,
  input wire logic [7:0]  C_INPUT_INDEX,
  input wire logic [3:0]  INT_PHASE_ONE,
  input wire logic [3:0]  INT_PHASE_TWO,
  input wire logic [3:0]  SAMPLE_INPUT,
  input wire logic [3:0]  SAMPLE_REF,
  input wire logic [3:0]  BUS_CONNECT
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  for (genvar k = 0; k < 4; k++)
  begin : g_blk
    ac_pair_a: assert property ((C_INPUT_INDEX[2*k+:2] == 2'h1) == (A_INPUT_INDEX[3*k+:3] == 3'h4))
      else $error("c source not tied to neighbour code");
    mux_resv_a: assert property ((C_INPUT_INDEX[2*k+:2] == 2'h3) == (A_INPUT_INDEX[3*k+:3] == 3'h7))
      else $error("reserved mux decode mismatch");
    ph_split_a: assert property (!(INT_PHASE_ONE[k] && INT_PHASE_TWO[k]))
      else $error("internal phases overlap");
    samp_excl_a: assert property (!(SAMPLE_INPUT[k] && SAMPLE_REF[k]))
      else $error("input and reference sampled together");
    // the gate and INT_PHASE_TWO are registered from the same phase in the same cycle
    bus_ph2_a: assert property (BUS_CONNECT[k] |-> INT_PHASE_TWO[k] || $past(INT_PHASE_TWO[k]))
      else $error("bus driven outside phase two");
  end
  rd_byte_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0 && !S_AXI_ARREADY)
    else $error("read data upper bytes or ready wrong");
  rd_close_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read response not closed");
  wr_close_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response not closed");
endmodule
bind sca_ctrl sca_ctrl_properties u_props (
  .CLOCK(CLOCK), .RESETN(RESETN), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .A_INPUT_INDEX(A_INPUT_INDEX), .C_INPUT_INDEX(C_INPUT_INDEX),
  .INT_PHASE_ONE(INT_PHASE_ONE), .INT_PHASE_TWO(INT_PHASE_TWO), .SAMPLE_INPUT(SAMPLE_INPUT),
  .SAMPLE_REF(SAMPLE_REF), .BUS_CONNECT(BUS_CONNECT));
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for sca_ctrl: axi4-lite registers and phase pins
// assumes sca_defines.vh on the include path; inputs move at rising edges
`timescale 1ns/1ps
`default_nettype none
`include "sca_defines.vh"
module testbench;
  logic        CLOCK, RESETN, awvalid, wvalid, bready, arvalid, rready, ph1, ph2;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [3:0]  feedback_cap_select, iph1, iph2, sin, sref, busc;
  wire  [19:0] a_path_cap_size, b_path_cap_size;
  wire  [11:0] aidx;
  wire  [7:0]  cidx;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  logic [7:0]  cr[8];
  logic [7:0]  ix[8];
  logic [15:0] s;
  int          miscompares, checks_done, cyc;
  sca_ctrl dut (
    .CLOCK(CLOCK), .RESETN(RESETN), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PHASE_ONE(ph1),
    .PHASE_TWO(ph2), .FEEDBACK_CAP_32(feedback_cap_select), .A_PATH_CAP_SIZE(a_path_cap_size), .B_PATH_CAP_SIZE(b_path_cap_size),
    .A_INPUT_INDEX(aidx), .C_INPUT_INDEX(cidx), .INT_PHASE_ONE(iph1), .INT_PHASE_TWO(iph2),
    .SAMPLE_INPUT(sin), .SAMPLE_REF(sref), .BUS_CONNECT(busc));
  task summarize;
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    bit aw, w;
    @(posedge CLOCK);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bq.push_back(r);
    aw = 1;
    w = 1;
    // address and data are released each at its own handshake
    while (aw || w)
    begin
      @(posedge CLOCK);
      aw = aw && !awready;
      w = w && !wready;
      awvalid <= aw;
      wvalid <= w;
    end
    do @(posedge CLOCK); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge CLOCK);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rq.push_back({r, 24'h0, d});
    do @(posedge CLOCK); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge CLOCK); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  task dec;
    logic [2:0] c;
    @(negedge CLOCK);
    for (int k = 0; k < 4; k++)
    begin
      c = cr[2*k+1][7:5];
      chk(feedback_cap_select[k], cr[2*k][7]);
      chk(a_path_cap_size[5*k+:5], cr[2*k][4:0]);
      chk(b_path_cap_size[5*k+:5], cr[2*k+1][4:0]);
      chk(aidx[3*k+:3], c < 4 ? c : (c == 4 ? `SCA_MUX_NEIGHBOR : `SCA_MUX_RESERVED));
      chk(cidx[2*k+:2], c < 4 ? `SCA_CSRC_FIXED : (c == 4 ? `SCA_CSRC_SAME_A : `SCA_CSRC_NONE));
    end
  endtask
  // one 46-cycle frame: phase one 0..19, phase two 23..42; checks sit well clear of sync lag
  task frame(input int m);
    for (int i = 0; i < 46; i++)
    begin
      @(posedge CLOCK);
      ph1 <= i < 20;
      ph2 <= i > 22 && i < 43;
      if (m > 0 && (i == 10 || i == 33 || i == 41))
      begin
        @(negedge CLOCK);
        if (i == 10) chk(busc[1], 1);
        if (i == 10) chk({sin[0], sin[2], sref[2]}, 3'b101);
        if (i == 10) chk(busc[0], 0);
        if (i == 10) chk(busc[3], 0);
        if (i == 33) chk(iph1[1], 1);
        if (i == 33) chk({iph1[0], iph2[0], iph2[1]}, 3'b010);
        if (i == 33) chk(busc[0], m == 2);
        if (i == 41) chk(busc[0], 1);
        if (i == 41) chk(busc[3], 0);
      end
    end
  endtask
  always @(posedge CLOCK)
  begin
    if (bvalid && bready) chk(bresp, bq.pop_front());
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
  end
  always @(posedge CLOCK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      summarize();
    end
  end
  initial
  begin
    CLOCK = 0;
    forever #12.5 CLOCK = ~CLOCK;
  end
  initial
  begin
    {RESETN, awvalid, wvalid, bready, arvalid, rready, ph1, ph2} = 8'h00;
    {awaddr, araddr, wdata} = 56'h0;
    wstrb = 4'h1;
    s = 16'd21707;
    ix = '{8'h80, 8'h81, 8'h88, 8'h89, 8'h94, 8'h95, 8'h9C, 8'h9D};
    repeat (8) @(posedge CLOCK);
    RESETN <= 1'b1;
    @(negedge CLOCK);
    chk({feedback_cap_select, a_path_cap_size, b_path_cap_size, aidx, cidx}, 64'h0);
    for (int k = 0; k < 8; k++) rd({ix[k], 2'b00} + 12'h400, 8'h00, `SCA_RESP_OKAY);
    rd(12'h000, 8'h00, `SCA_RESP_SLVERR);
    wr(12'h004, 8'h5A, `SCA_RESP_SLVERR);
    // mux field steps through every code that software may program
    for (int r = 0; r < 5; r++)
    begin
      for (int k = 0; k < 8; k++)
      begin
        s = nx(s);
        cr[k] = k[0] ? {r[2:0], s[4:0]} : s[7:0];
        wr({1'b0, r[0], ix[k], 2'b00}, cr[k], `SCA_RESP_OKAY);
        rd({1'b0, ~r[0], ix[k], 2'b00}, cr[k], `SCA_RESP_OKAY);
      end
      dec();
    end
    wr(12'h200, 8'h00, `SCA_RESP_OKAY);
    wr(12'h220, 8'h40, `SCA_RESP_OKAY);
    wr(12'h250, 8'h20, `SCA_RESP_OKAY);
    wr(12'h270, 8'h40, `SCA_RESP_OKAY);
    wr(12'h280, 8'h07, `SCA_RESP_OKAY);
    // first phase two after reset never reaches its late half, so settle first
    repeat (3) frame(0);
    repeat (2) frame(1);
    wr(12'h280, 8'h47, `SCA_RESP_OKAY);
    frame(2);
    summarize();
  end
endmodule
`default_nettype wire
